// ==== logic/tcr_pkg.sv ====
// Package of constants and types for the trace control register set.
package tcr_pkg;

    // Debug instruction codes that select a register on the instruction port.
    localparam logic [7:0] TCR_INSN_DATA     = 8'h12;
    localparam logic [7:0] TCR_INSN_COH_CTRL = 8'h15;
    localparam logic [7:0] TCR_INSN_PERF     = 8'h16;

    // Memory-mapped debug segment offsets.
    localparam logic [15:0] TCR_OFS_COH_CTRL = 16'h3018;
    localparam logic [15:0] TCR_OFS_PERF     = 16'h3020;
    // Offset of the master-select register within the global debug block.
    localparam logic [15:0] TCR_OFS_MASTER   = 16'h0000;

    // Coherence trace control field positions.
    localparam int TCR_CT_MASTER_EN = 0;
    localparam int TCR_CT_CORE_EN   = 1;
    localparam int TCR_CT_ADDR_EN   = 2;
    localparam int TCR_CT_LEV_LO    = 3;
    localparam int TCR_CT_LEV_HI    = 4;
    localparam int TCR_CT_INHIBIT   = 5;
    localparam int TCR_CT_WB        = 7;
    localparam int TCR_CT_SRC_LO    = 8;
    localparam int TCR_CT_SRC_HI    = 11;

    // Performance counter trace control field positions.
    localparam int TCR_PC_PRESENT = 0;
    localparam int TCR_PC_ENABLE  = 1;
    localparam int TCR_PC_SYNC    = 2;
    localparam int TCR_PC_BP      = 3;
    localparam int TCR_PC_CALLRET = 4;
    localparam int TCR_PC_OVF     = 5;
    localparam int TCR_PC_IDLE    = 8;

    // Master-select field positions.
    localparam int TCR_MS_CORE_LO = 0;
    localparam int TCR_MS_CORE_HI = 3;
    localparam int TCR_MS_SELECT  = 4;

    // Reset values.
    localparam logic [6:0] TCR_COH_RST  = 7'h00;
    localparam logic [5:0] TCR_PERF_RST = 6'h00;
    localparam logic [4:0] TCR_MS_RST   = 5'h00;
    localparam logic       TCR_IDLE_RST = 1'b1;
    localparam logic [63:0] TCR_DATA_RST = 64'h0;

    // Number of cores sharing the coherence manager.
    localparam int TCR_NUM_CORES = 4;

    // Trace level codes.
    typedef enum logic [1:0] {
        TCR_LEV_PLAIN = 2'b00,
        TCR_LEV_STALL = 2'b01,
        TCR_LEV_RSV2  = 2'b10,
        TCR_LEV_RSV3  = 2'b11
    } tcr_level_t;

    // Indirect-access target codes.
    typedef enum logic [1:0] {
        TCR_TGT_COH   = 2'b00,
        TCR_TGT_PERF  = 2'b01,
        TCR_TGT_WORD  = 2'b10,
        TCR_TGT_OTHER = 2'b11
    } tcr_target_t;

endpackage

// ==== logic/tcr_ctrl_if.sv ====
// Interface carrying decoded register writes into the trigger gate.
`timescale 1ns/1ps
`default_nettype none
interface tcr_ctrl_if;
    logic       perf_enable;
    logic [3:0] perf_triggers;
    logic       overflow_evt;
    logic       callret_evt;
    logic       bp_evt;
    logic       sync_evt;
    logic       emit;
    modport ctrl (output perf_enable, output perf_triggers,
                  output overflow_evt, output callret_evt,
                  output bp_evt, output sync_evt, input emit);
    modport gate (input perf_enable, input perf_triggers,
                  input overflow_evt, input callret_evt,
                  input bp_evt, input sync_evt, output emit);
endinterface
`default_nettype wire

// ==== logic/tcr_perf_gate.sv ====
// Performance counter trace trigger gate.
`timescale 1ns/1ps
`default_nettype none
module tcr_perf_gate
    import tcr_pkg::*;
(
    tcr_ctrl_if.gate g
);
    // Triggers order: [0] sync, [1] breakpoint, [2] call/return, [3] overflow.
    assign g.emit = g.perf_enable &
                    ((g.perf_triggers[3] & g.overflow_evt) |
                     (g.perf_triggers[2] & g.callret_evt)  |
                     (g.perf_triggers[1] & g.bp_evt)       |
                     (g.perf_triggers[0] & g.sync_evt));
endmodule
`default_nettype wire

// ==== logic/tcr_regs.sv ====
// Trace control register set with coherence and performance trace gating.
// Function
// - Writeback bit passes or suppresses writeback trace.
// - Inhibit plus full FIFO stalls coherence manager.
// - Level 00 plain, 01 adds stall causes.
// - Address bit forces serialization-point address trace.
// - Per-core enable bypasses master core selection.
// - Effective per-core enable ORs all cores, software.
// - Coherence register reserved fields read zero.
// - Source identifier is read-only field.
// - Master-select holds core number, resets zero.
// - Select bit picks hardware or software control.
// - Idle flag read-only, resets one.
// - Overflow trigger emits counter values.
// - Call, return, exception trigger emits values.
// - Breakpoint trigger emits counter values.
// - Sync expiry trigger emits counter values.
// - Counter trace enable gates every trigger.
// - Present bit reports counter tracing exists.
// - Perf register at insn 16h, offset 3020h.
// - Indirect data writes target only when enabled.
// - Indirect data 64 bits for trace words.
// - Perf register reserved fields read zero.
// - Coherence register at insn 15h, offset 3018h.
`timescale 1ns/1ps
`default_nettype none
module tcr_regs
    import tcr_pkg::*;
#(
    parameter logic       COUNTER_TRACE_PRESENT = 1'b1,
    parameter logic [3:0] COHERENCE_SOURCE_ID   = 4'h0
)(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Debug instruction port: a write or read of the selected register.
    input  wire logic [7:0]  insn_code,
    input  wire logic        insn_write,
    input  wire logic        insn_read,
    input  wire logic [63:0] insn_wdata,
    output logic [63:0]      insn_rdata,
    // Memory-mapped debug segment access.
    input  wire logic [15:0] mm_addr,
    input  wire logic        mm_write,
    input  wire logic        mm_read,
    input  wire logic [31:0] mm_wdata,
    output logic [31:0]      mm_rdata,
    // Global debug block access to the master-select register.
    input  wire logic [15:0] gdb_addr,
    input  wire logic        gdb_write,
    input  wire logic [31:0] gdb_wdata,
    output logic [31:0]      gdb_rdata,
    // Indirect-access selection and write enable from the control block.
    input  wire logic [1:0]  indirect_select,
    input  wire logic        indirect_write_enable,
    input  wire logic [63:0] trace_word_rdata,
    output logic             trace_word_we,
    output logic [63:0]      trace_word_wdata,
    output logic [31:0]      other_reg_wdata,
    output logic             other_reg_we,
    input  wire logic [31:0] other_reg_rdata,
    // Coherence manager side.
    input  wire logic        writeback_req,
    input  wire logic        coherence_fifo_full,
    input  wire logic [TCR_NUM_CORES-1:0] per_core_coherence_enable,
    input  wire logic        software_trace_on,
    input  wire logic        hw_trace_enable,
    input  wire logic        trace_busy,
    output logic             writeback_trace,
    output logic             coherence_stall,
    output logic [1:0]       coherence_trace_level,
    output logic             address_trace_enable,
    output logic             coherence_trace_on,
    output logic             effective_core_enable,
    // Core trace side: performance counter trigger events.
    input  wire logic        overflow_event,
    input  wire logic        callret_event,
    input  wire logic        breakpoint_event,
    input  wire logic        sync_event,
    output logic             counter_trace_emit
);

    logic       writeback_trace_enable;
    logic       overflow_inhibit;
    logic [1:0] level_field;
    logic       addr_en;
    logic       core_en;
    logic       coherence_master_enable;
    logic [5:0] perf_bits;
    logic [3:0] master_core_number;
    logic       trace_control_source_select;
    logic       trace_idle_flag;
    logic [63:0] indirect_trace_data;
    logic [31:0] coh_view;
    logic [31:0] perf_view;
    logic       coh_wr;
    logic       perf_wr;
    logic       ind_wr;
    logic [63:0] coh_wval;
    logic [63:0] perf_wval;
    logic [63:0] ind_rval;
    logic       gate_on;

    tcr_ctrl_if cif ();

    assign coh_view = {16'h0000, 4'h0, COHERENCE_SOURCE_ID,
                       writeback_trace_enable, 1'b0, overflow_inhibit,
                       level_field, addr_en, core_en,
                       coherence_master_enable};
    assign perf_view = {23'h000000, trace_idle_flag, 2'b00,
                        perf_bits[5:1],
                        COUNTER_TRACE_PRESENT};

    // Indirect accesses write the selected target only with write enable.
    assign ind_wr = insn_write && insn_code == TCR_INSN_DATA &&
                    indirect_write_enable;

    assign coh_wr = (insn_write && insn_code == TCR_INSN_COH_CTRL) ||
                    (mm_write && mm_addr == TCR_OFS_COH_CTRL) ||
                    (ind_wr && indirect_select == TCR_TGT_COH);
    assign perf_wr = (insn_write && insn_code == TCR_INSN_PERF) ||
                     (mm_write && mm_addr == TCR_OFS_PERF) ||
                     (ind_wr && indirect_select == TCR_TGT_PERF);

    always_comb begin
        if (ind_wr) begin
            coh_wval = insn_wdata;
        end else if (insn_write) begin
            coh_wval = insn_wdata;
        end else begin
            coh_wval = {32'h00000000, mm_wdata};
        end
        perf_wval = coh_wval;
    end

    // Coherence trace control fields.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {writeback_trace_enable, overflow_inhibit, level_field,
             addr_en, core_en, coherence_master_enable} <= TCR_COH_RST;
        end else if (coh_wr) begin
            writeback_trace_enable  <= coh_wval[TCR_CT_WB];
            overflow_inhibit        <= coh_wval[TCR_CT_INHIBIT];
            level_field             <= coh_wval[TCR_CT_LEV_HI:TCR_CT_LEV_LO];
            addr_en                 <= coh_wval[TCR_CT_ADDR_EN];
            core_en                 <= coh_wval[TCR_CT_CORE_EN];
            coherence_master_enable <= coh_wval[TCR_CT_MASTER_EN];
        end
    end

    // Performance counter trace control fields; bit 0 is the preset.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            perf_bits <= TCR_PERF_RST;
        end else if (perf_wr) begin
            perf_bits <= {perf_wval[TCR_PC_OVF:TCR_PC_ENABLE], 1'b0};
        end
    end

    // Master-select register in the global debug block.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {trace_control_source_select, master_core_number} <= TCR_MS_RST;
        end else if (gdb_write && gdb_addr == TCR_OFS_MASTER) begin
            master_core_number <=
                gdb_wdata[TCR_MS_CORE_HI:TCR_MS_CORE_LO];
            trace_control_source_select <= gdb_wdata[TCR_MS_SELECT];
        end
    end

    // Idle flag follows the trace hardware.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trace_idle_flag <= TCR_IDLE_RST;
        end else begin
            trace_idle_flag <= ~trace_busy;
        end
    end

    // Indirect data register: 64 bits for trace words, else 32.
    always_comb begin
        unique case (tcr_target_t'(indirect_select))
            TCR_TGT_COH:   ind_rval = {32'h00000000, coh_view};
            TCR_TGT_PERF:  ind_rval = {32'h00000000, perf_view};
            TCR_TGT_WORD:  ind_rval = trace_word_rdata;
            TCR_TGT_OTHER: ind_rval = {32'h00000000, other_reg_rdata};
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            indirect_trace_data <= TCR_DATA_RST;
        end else if (insn_read && insn_code == TCR_INSN_DATA) begin
            indirect_trace_data <= ind_rval;
        end else if (ind_wr) begin
            indirect_trace_data <= (indirect_select == TCR_TGT_WORD) ?
                insn_wdata : {32'h00000000, insn_wdata[31:0]};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trace_word_we    <= 1'b0;
            other_reg_we     <= 1'b0;
            trace_word_wdata <= TCR_DATA_RST;
            other_reg_wdata  <= 32'h00000000;
        end else begin
            trace_word_we <= ind_wr && indirect_select == TCR_TGT_WORD;
            other_reg_we  <= ind_wr && indirect_select == TCR_TGT_OTHER;
            if (ind_wr) begin
                trace_word_wdata <= insn_wdata;
                other_reg_wdata  <= insn_wdata[31:0];
            end
        end
    end

    always_comb begin
        unique case (insn_code)
            TCR_INSN_COH_CTRL: insn_rdata = {32'h00000000, coh_view};
            TCR_INSN_PERF:     insn_rdata = {32'h00000000, perf_view};
            TCR_INSN_DATA:     insn_rdata = indirect_trace_data;
            default:           insn_rdata = 64'h0;
        endcase
    end

    always_comb begin
        mm_rdata = 32'h00000000;
        if (mm_read && mm_addr == TCR_OFS_COH_CTRL) begin
            mm_rdata = coh_view;
        end else if (mm_read && mm_addr == TCR_OFS_PERF) begin
            mm_rdata = perf_view;
        end
    end

    assign gdb_rdata = (gdb_addr == TCR_OFS_MASTER) ?
        {27'h0000000, trace_control_source_select, master_core_number} :
        32'h00000000;

    // Coherence trace gating toward the coherence manager.
    // This core's own enable bit joins the other cores' bits in the OR.
    assign effective_core_enable = core_en |
                                   (|per_core_coherence_enable) |
                                   software_trace_on;
    assign gate_on = trace_control_source_select ? software_trace_on :
                                                   hw_trace_enable;
    assign coherence_trace_on = coherence_master_enable &&
                                (gate_on || effective_core_enable);
    assign writeback_trace = coherence_trace_on &&
                             writeback_trace_enable && writeback_req;
    assign coherence_stall = coherence_trace_on && overflow_inhibit &&
                             coherence_fifo_full;
    assign coherence_trace_level = level_field;
    assign address_trace_enable = coherence_trace_on && addr_en;

    // Performance counter trigger gate.
    assign cif.perf_enable   = perf_bits[TCR_PC_ENABLE] &
                               COUNTER_TRACE_PRESENT;
    assign cif.perf_triggers = perf_bits[TCR_PC_OVF:TCR_PC_SYNC];
    assign cif.overflow_evt  = overflow_event;
    assign cif.callret_evt   = callret_event;
    assign cif.bp_evt        = breakpoint_event;
    assign cif.sync_evt      = sync_event;
    assign counter_trace_emit = cif.emit;

    tcr_perf_gate u_gate (
        .g (cif.gate)
    );

    AST_RESERVED_ZERO: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (mm_read && mm_addr == TCR_OFS_COH_CTRL)
        |-> mm_rdata[15:12] == 4'h0 && mm_rdata[6] == 1'b0)
        else $error("coherence reserved bits nonzero");
    AST_SRC_READ_ONLY: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (mm_read && mm_addr == TCR_OFS_COH_CTRL)
        |-> mm_rdata[TCR_CT_SRC_HI:TCR_CT_SRC_LO] == COHERENCE_SOURCE_ID)
        else $error("source identifier not presented");
    AST_PERF_RSV: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (insn_code == TCR_INSN_PERF)
        |-> insn_rdata[31:9] == 23'h0 && insn_rdata[7:6] == 2'b00)
        else $error("perf reserved bits nonzero");
    AST_MASTER_OFF: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !coherence_master_enable |-> !coherence_trace_on)
        else $error("coherence trace on while master disabled");
    AST_STALL: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        coherence_stall ==
        (coherence_trace_on && overflow_inhibit && coherence_fifo_full))
        else $error("stall does not follow full FIFO with inhibit");
    AST_WB_SUPPRESS: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !writeback_trace_enable |-> !writeback_trace)
        else $error("writeback traced while disabled");
    AST_ADDR_OFF: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !coherence_trace_on |-> !address_trace_enable)
        else $error("address trace while coherence trace off");
    AST_PERF_GATE: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !perf_bits[TCR_PC_ENABLE] |-> !counter_trace_emit)
        else $error("counter trace without enable");
    AST_COH_WRITE: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (insn_write && insn_code == TCR_INSN_COH_CTRL)
        |=> addr_en == $past(insn_wdata[TCR_CT_ADDR_EN]))
        else $error("coherence write not applied next cycle");
    AST_PERF_WRITE: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (mm_write && mm_addr == TCR_OFS_PERF && !insn_write)
        |=> perf_bits[TCR_PC_ENABLE] == $past(mm_wdata[TCR_PC_ENABLE]))
        else $error("perf write not applied next cycle");
    AST_MASTER_WRITE: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (gdb_write && gdb_addr == TCR_OFS_MASTER)
        |=> {trace_control_source_select, master_core_number} ==
            $past(gdb_wdata[TCR_MS_SELECT:TCR_MS_CORE_LO]))
        else $error("master-select write not applied next cycle");
    AST_IND_NOWR: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (insn_write && insn_code == TCR_INSN_DATA && !indirect_write_enable)
        |=> !trace_word_we && !other_reg_we)
        else $error("indirect write without enable");
    AST_IND_WIDTH: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (insn_read && insn_code == TCR_INSN_DATA &&
         indirect_select != TCR_TGT_WORD)
        |=> indirect_trace_data[63:32] == 32'h0)
        else $error("narrow indirect read has upper bits set");
    AST_IDLE: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        trace_busy |=> !trace_idle_flag)
        else $error("idle flag set while busy");
    AST_IDLE_SET: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !trace_busy |=> trace_idle_flag)
        else $error("idle flag clear while not busy");

    COV_WB: cover property (@(posedge ref_clk) writeback_trace);
    COV_STALL: cover property (@(posedge ref_clk) coherence_stall);
    COV_EMIT: cover property (@(posedge ref_clk) counter_trace_emit);
    COV_IND: cover property (@(posedge ref_clk) trace_word_we);
    COV_LEVEL: cover property (@(posedge ref_clk)
        coherence_trace_level == TCR_LEV_STALL);

endmodule
`default_nettype wire

// ==== testbench/tcr_far_model.sv ====
// Far-side model of the trace word store and the other indirect target.
`timescale 1ns/1ps
`default_nettype none
module tcr_far_model
    import tcr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        trace_word_we,
    input  wire logic [63:0] trace_word_wdata,
    output logic [63:0]      trace_word_rdata,
    input  wire logic        other_reg_we,
    input  wire logic [31:0] other_reg_wdata,
    output logic [31:0]      other_reg_rdata
);
    logic [63:0] word_store;
    logic [31:0] other_store;

    // The full 64-bit word is stored; the other target keeps 32 bits.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            word_store <= 64'h0;
        end else if (trace_word_we) begin
            word_store <= trace_word_wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            other_store <= 32'h0;
        end else if (other_reg_we) begin
            other_store <= other_reg_wdata;
        end
    end

    assign trace_word_rdata = word_store;
    assign other_reg_rdata  = other_store;
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the trace control register set.
`timescale 1ns/1ps
`default_nettype none
module tb
    import tcr_pkg::*;
;
    localparam logic [3:0] SRC_ID      = 4'h9;
    localparam int         CYCLE_LIMIT = 3000;
    logic        ref_clk, sys_rst, insn_write, insn_read, mm_write, mm_read;
    logic        gdb_write, ind_we, trace_word_we, other_reg_we;
    logic [7:0]  insn_code;
    logic [63:0] insn_wdata, insn_rdata, trace_word_rdata, trace_word_wdata;
    logic [15:0] mm_addr, gdb_addr;
    logic [31:0] mm_wdata, mm_rdata, gdb_wdata, gdb_rdata;
    logic [31:0] other_reg_wdata, other_reg_rdata;
    logic [1:0]  ind_sel, level;
    logic [3:0]  per_core, evt;
    logic        wb_req, fifo_full, sw_on, hw_en, busy, wb_trace, stall;
    logic        addr_en, trace_on, eff_en, emit;
    logic [63:0] rd;
    int          errors, tests_run, cycles;

    tcr_regs #(.COUNTER_TRACE_PRESENT(1'b1), .COHERENCE_SOURCE_ID(SRC_ID)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .insn_code(insn_code),
        .insn_write(insn_write), .insn_read(insn_read),
        .insn_wdata(insn_wdata), .insn_rdata(insn_rdata),
        .mm_addr(mm_addr), .mm_write(mm_write), .mm_read(mm_read),
        .mm_wdata(mm_wdata), .mm_rdata(mm_rdata), .gdb_addr(gdb_addr),
        .gdb_write(gdb_write), .gdb_wdata(gdb_wdata), .gdb_rdata(gdb_rdata),
        .indirect_select(ind_sel), .indirect_write_enable(ind_we),
        .trace_word_rdata(trace_word_rdata), .trace_word_we(trace_word_we),
        .trace_word_wdata(trace_word_wdata),
        .other_reg_wdata(other_reg_wdata), .other_reg_we(other_reg_we),
        .other_reg_rdata(other_reg_rdata), .writeback_req(wb_req),
        .coherence_fifo_full(fifo_full), .per_core_coherence_enable(per_core),
        .software_trace_on(sw_on), .hw_trace_enable(hw_en),
        .trace_busy(busy), .writeback_trace(wb_trace),
        .coherence_stall(stall), .coherence_trace_level(level),
        .address_trace_enable(addr_en), .coherence_trace_on(trace_on),
        .effective_core_enable(eff_en), .overflow_event(evt[3]),
        .callret_event(evt[2]), .breakpoint_event(evt[1]),
        .sync_event(evt[0]), .counter_trace_emit(emit));

    tcr_far_model far (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .trace_word_we(trace_word_we),
        .trace_word_wdata(trace_word_wdata),
        .trace_word_rdata(trace_word_rdata), .other_reg_we(other_reg_we),
        .other_reg_wdata(other_reg_wdata), .other_reg_rdata(other_reg_rdata));

    always #25 ref_clk = ~ref_clk;

    task automatic complete_run();
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= CYCLE_LIMIT) begin
            errors++;
            complete_run();
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic insn_wr(input logic [7:0] code, input logic [63:0] data);
        @(negedge ref_clk);
        insn_code = code;
        insn_wdata = data;
        insn_write = 1'b1;
        @(negedge ref_clk);
        insn_write = 1'b0;
    endtask

    // Read data is taken at the falling edge after the capture edge.
    task automatic insn_rd(input logic [7:0] code);
        @(negedge ref_clk);
        insn_code = code;
        insn_read = 1'b1;
        @(negedge ref_clk);
        rd = insn_rdata;
        insn_read = 1'b0;
    endtask

    task automatic mm_wr(input logic [15:0] addr, input logic [31:0] data);
        @(negedge ref_clk);
        mm_addr = addr;
        mm_wdata = data;
        mm_write = 1'b1;
        @(negedge ref_clk);
        mm_write = 1'b0;
    endtask

    task automatic mm_rd(input logic [15:0] addr);
        @(negedge ref_clk);
        mm_addr = addr;
        mm_read = 1'b1;
        @(negedge ref_clk);
        rd = {32'h0, mm_rdata};
        mm_read = 1'b0;
    endtask

    task automatic gdb_wr(input logic [31:0] data);
        @(negedge ref_clk);
        gdb_wdata = data;
        gdb_write = 1'b1;
        @(negedge ref_clk);
        gdb_write = 1'b0;
        #1 rd = {32'h0, gdb_rdata};
    endtask

    task automatic t_reset();
        insn_rd(TCR_INSN_COH_CTRL);
        check(rd, {52'h0, SRC_ID, 8'h00});
        insn_rd(TCR_INSN_PERF);
        check(rd, 64'h101);
        #1 check({32'h0, gdb_rdata}, 64'h0);
        mm_rd(16'h3000);
        check(rd, 64'h0);
        insn_rd(8'h13);
        check(rd, 64'h0);
    endtask

    task automatic t_coherence();
        insn_wr(TCR_INSN_COH_CTRL, 64'h0FBF);
        #1 check(64'({wb_trace, stall, level, addr_en}), 64'h1F);
        mm_rd(TCR_OFS_COH_CTRL);
        check(rd, {52'h0, SRC_ID, 8'hBF});
        fifo_full = 1'b0;
        #1 check({63'h0, stall}, 64'h0);
        for (int lev = 0; lev < 4; lev++) begin
            mm_wr(TCR_OFS_COH_CTRL, 32'h81 | (32'(lev) << 3));
            fifo_full = 1'b1;
            #1 check({62'h0, level}, 64'(lev));
            check(64'({wb_trace, stall, addr_en}), 64'h4);
        end
        mm_wr(TCR_OFS_COH_CTRL, 32'h1);
        #1 check({63'h0, wb_trace}, 64'h0);
    endtask

    task automatic t_enables();
        per_core = 4'hF;
        mm_wr(TCR_OFS_COH_CTRL, 32'h0);
        #1 check({63'h0, trace_on}, 64'h0);
        per_core = 4'h0;
        hw_en = 1'b0;
        mm_wr(TCR_OFS_COH_CTRL, 32'h1);
        #1 check(64'({eff_en, trace_on}), 64'h0);
        mm_wr(TCR_OFS_COH_CTRL, 32'h3);
        #1 check(64'({eff_en, trace_on}), 64'h3);
        mm_wr(TCR_OFS_COH_CTRL, 32'h1);
        per_core = 4'b0100;
        #1 check(64'({eff_en, trace_on}), 64'h3);
        per_core = 4'h0;
        sw_on = 1'b1;
        #1 check({63'h0, eff_en}, 64'h1);
        sw_on = 1'b0;
        hw_en = 1'b1;
        #1 check({63'h0, trace_on}, 64'h1);
        gdb_wr(32'h0000_001F);
        check(rd, 64'h1F);
        check({63'h0, trace_on}, 64'h0);
        gdb_wr(32'h0);
    endtask

    task automatic t_perf();
        mm_wr(TCR_OFS_PERF, 32'h0000_003E);
        insn_rd(TCR_INSN_PERF);
        check(rd, 64'h13F);
        busy = 1'b1;
        mm_rd(TCR_OFS_PERF);
        check(rd, 64'h03F);
        busy = 1'b0;
        for (int k = 0; k < 4; k++) begin
            insn_wr(TCR_INSN_PERF, 64'h2 | (64'h4 << k));
            for (int j = 0; j < 4; j++) begin
                @(negedge ref_clk);
                evt = 4'(1 << j);
                #1 check({63'h0, emit}, 64'(j == k));
            end
            @(negedge ref_clk);
            evt = 4'h0;
        end
        mm_wr(TCR_OFS_PERF, 32'h3C);
        @(negedge ref_clk);
        evt = 4'hF;
        #1 check({63'h0, emit}, 64'h0);
        @(negedge ref_clk);
        evt = 4'h0;
    endtask

    task automatic t_indirect();
        ind_sel = TCR_TGT_WORD;
        ind_we = 1'b1;
        insn_wr(TCR_INSN_DATA, 64'hA5A5_0F0F_1234_5678);
        #1 check({trace_word_we, trace_word_wdata[63:1]}, 64'hD2D2_8787_891A_2B3C);
        insn_rd(TCR_INSN_DATA);
        check(rd, 64'hA5A5_0F0F_1234_5678);
        ind_sel = TCR_TGT_OTHER;
        insn_wr(TCR_INSN_DATA, 64'hFFFF_FFFF_CAFE_0001);
        #1 check(64'({other_reg_we, other_reg_wdata}), 64'h1CAFE0001);
        ind_we = 1'b0;
        insn_wr(TCR_INSN_DATA, 64'h5);
        #1 check({63'h0, other_reg_we}, 64'h0);
        insn_rd(TCR_INSN_DATA);
        check(rd, 64'hCAFE_0001);
        ind_sel = TCR_TGT_PERF;
        ind_we = 1'b1;
        insn_wr(TCR_INSN_DATA, 64'h22);
        insn_rd(TCR_INSN_PERF);
        check(rd, 64'h123);
    endtask

    initial begin
        {ref_clk, insn_write, insn_read, mm_write, mm_read, gdb_write} = '0;
        {insn_code, insn_wdata, mm_addr, mm_wdata, gdb_addr, gdb_wdata} = '0;
        {ind_sel, ind_we, per_core, evt, sw_on, busy} = '0;
        {errors, tests_run, cycles} = '0;
        fifo_full = 1'b1;
        hw_en = 1'b1;
        wb_req = 1'b1;
        sys_rst = 1'b1;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        t_reset();
        t_coherence();
        t_enables();
        t_perf();
        t_indirect();
        complete_run();
    end
endmodule
`default_nettype wire
